/* File: verilog/dmt_pkg.sv */
// Constants for the rail compensation and mode transition register bank
package dmt_pkg;
   // Register byte addresses
   localparam logic [7:0] RAIL_A_COMP_OFS  = 8'h00;
   localparam logic [7:0] RAIL_B_COMP_OFS  = 8'h01;
   // Reset values, bits 7..0 as printed per rail
   localparam logic [7:0] RAIL_A_COMP_RST  = 8'h0c;
   localparam logic [7:0] RAIL_B_COMP_RST  = 8'h94;
   // Answer to an unmapped read
   localparam logic [7:0] UNMAPPED_RDATA   = 8'h00;
   // Field positions inside each rail register
   localparam int FIXED_LIFT_OFF_BIT       = 7;
   localparam int PULL_SCALE_MSB           = 6;
   localparam int PULL_SCALE_LSB           = 4;
   localparam int EXIT_LIFT_BIT            = 3;
   localparam int FILTER_CLEAR_BIT         = 2;
   localparam int GAIN_DOUBLE_BIT          = 1;
   localparam int RIPPLE_DOUBLE_BIT        = 0;
   // Field widths
   localparam int PULL_SCALE_W             = 3;
   localparam int LIFT_SETTING_W           = 4;
   localparam int GAIN_CODE_W              = 3;
   localparam int RIPPLE_CODE_W            = 3;
   // Pull current in quarters of the lift setting
   localparam int PULL_CURRENT_W           = LIFT_SETTING_W + PULL_SCALE_W;
   localparam int GAIN_EFF_W               = GAIN_CODE_W + 1;
   localparam int RIPPLE_EFF_W             = RIPPLE_CODE_W + 1;
   // Fixed lift level during a downward ramp, in millivolts
   localparam int FIXED_LIFT_MV            = 15;
   // Pull scale code that turns the ramp-down pull off
   localparam logic [2:0] PULL_SCALE_OFF   = 3'h0;
endpackage

/* File: verilog/dmt_rail_if.sv */
// Per-rail bundle between the register bank and the rail control decoder
`timescale 1ns/1ps
interface dmt_rail_if;
   logic [7:0]                         cfg;
   logic [dmt_pkg::LIFT_SETTING_W-1:0] lift_setting;
   logic [dmt_pkg::GAIN_CODE_W-1:0]    gain_code;
   logic [dmt_pkg::RIPPLE_CODE_W-1:0]  ripple_code;
   logic                               fixed_lift_en;
   logic [dmt_pkg::PULL_SCALE_W-1:0]   pull_scale;
   logic [dmt_pkg::PULL_CURRENT_W-1:0] pull_current;
   logic                               exit_lift;
   logic                               filter_clear;
   logic                               gain_double;
   logic [dmt_pkg::GAIN_EFF_W-1:0]     gain_eff;
   logic                               ripple_double;
   logic [dmt_pkg::RIPPLE_EFF_W-1:0]   ripple_eff;

   // Register side supplies the settings and takes the decoded controls
   modport bank (
      output cfg,
      output lift_setting,
      output gain_code,
      output ripple_code,
      input  fixed_lift_en,
      input  pull_scale,
      input  pull_current,
      input  exit_lift,
      input  filter_clear,
      input  gain_double,
      input  gain_eff,
      input  ripple_double,
      input  ripple_eff
   );
   // Decoder side
   modport rail (
      input  cfg,
      input  lift_setting,
      input  gain_code,
      input  ripple_code,
      output fixed_lift_en,
      output pull_scale,
      output pull_current,
      output exit_lift,
      output filter_clear,
      output gain_double,
      output gain_eff,
      output ripple_double,
      output ripple_eff
   );
endinterface

/* File: verilog/dmt_rail_ctrl.sv */
// Decoder turning one rail's register byte into registered loop controls
`timescale 1ns/1ps
module dmt_rail_ctrl (
   input  wire logic clk,
   input  wire logic rst_n,
   dmt_rail_if.rail  rif
);
   // Pull current in quarter units: code n means n quarters of the lift
   function automatic logic [dmt_pkg::PULL_CURRENT_W-1:0] pull_quarters(
      input logic [dmt_pkg::PULL_SCALE_W-1:0]   code,
      input logic [dmt_pkg::LIFT_SETTING_W-1:0] lift
   );
      logic [dmt_pkg::PULL_CURRENT_W-1:0] prod;
      prod = dmt_pkg::PULL_CURRENT_W'(lift) * dmt_pkg::PULL_CURRENT_W'(code);
      return prod;
   endfunction

   // Optional doubling of a 3-bit multiplier code
   function automatic logic [3:0] doubled(
      input logic [2:0] code,
      input logic       dbl
   );
      logic [3:0] r;
      r = dbl ? {code, 1'b0} : {1'b0, code};
      return r;
   endfunction

   logic [dmt_pkg::PULL_SCALE_W-1:0] scale;
   assign scale = rif.cfg[dmt_pkg::PULL_SCALE_MSB:dmt_pkg::PULL_SCALE_LSB];

   // Flag outputs; held until the register changes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rif.fixed_lift_en <= ~dmt_pkg::RAIL_A_COMP_RST[dmt_pkg::FIXED_LIFT_OFF_BIT];
         rif.exit_lift     <= 1'b0;
         rif.filter_clear  <= 1'b0;
         rif.gain_double   <= 1'b0;
         rif.ripple_double <= 1'b0;
      end else begin
         rif.fixed_lift_en <= ~rif.cfg[dmt_pkg::FIXED_LIFT_OFF_BIT];
         rif.exit_lift     <= rif.cfg[dmt_pkg::EXIT_LIFT_BIT];
         rif.filter_clear  <= rif.cfg[dmt_pkg::FILTER_CLEAR_BIT];
         rif.gain_double   <= rif.cfg[dmt_pkg::GAIN_DOUBLE_BIT];
         rif.ripple_double <= rif.cfg[dmt_pkg::RIPPLE_DOUBLE_BIT];
      end
   end

   // Scaled values; zero code gives zero pull, i.e. pull disabled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rif.pull_scale   <= dmt_pkg::PULL_SCALE_OFF;
         rif.pull_current <= '0;
         rif.gain_eff     <= '0;
         rif.ripple_eff   <= '0;
      end else begin
         rif.pull_scale   <= scale;
         rif.pull_current <= pull_quarters(scale, rif.lift_setting);
         rif.gain_eff     <= doubled(rif.gain_code,
                                     rif.cfg[dmt_pkg::GAIN_DOUBLE_BIT]);
         rif.ripple_eff   <= doubled(rif.ripple_code,
                                     rif.cfg[dmt_pkg::RIPPLE_DOUBLE_BIT]);
      end
   end
endmodule

/* File: verilog/dmt_comp_regs.sv */
// Rail A and B ramp and mode transition compensation register bank
//
// Operation
// - Bit 7 turns the fixed 15mV lift on a downward ramp off when 1 and on when 0; during reset the lift is on for both rails.
// - Rail A bits 6:4 pick a pull of 0 to 1.75 times its lift setting in quarter steps.
// - Rail B bits 6:4 scale its own lift setting the same way, with code 0 meaning off.
// - Bit 3 set to 1 lifts the voltage ID as the rail leaves the low-power state.
// - Bit 2 set to 1 clears the loop filter as the rail leaves the low-power state.
// - Rail A bit 1 set to 1 doubles rail A's current-sense gain.
// - Rail B bit 1 set to 1 doubles rail B's current-sense gain.
// - Rail A bit 0 set to 1 doubles rail A's ripple compensation multiplier.
// - Rail B bit 0 set to 1 doubles rail B's ripple compensation multiplier.
`timescale 1ns/1ps
module dmt_comp_regs (
   input  wire logic       CLK,
   input  wire logic       RSTN,
   // Byte register port from the serial configuration engine
   input  wire logic       REG_WR_EN,
   input  wire logic       REG_RD_EN,
   input  wire logic [7:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   output logic      [7:0] REG_RDATA,
   output logic            REG_RD_VALID,
   // Settings held in other registers of the controller
   input  wire logic [3:0] RAIL_A_LIFT_CURRENT_SETTING,
   input  wire logic [2:0] RAIL_A_SENSE_GAIN_CODE,
   input  wire logic [2:0] RAIL_A_RIPPLE_COMP_CODE,
   input  wire logic [3:0] RAIL_B_LIFT_CURRENT_SETTING,
   input  wire logic [2:0] RAIL_B_SENSE_GAIN_CODE,
   input  wire logic [2:0] RAIL_B_RIPPLE_COMP_CODE,
   // Rail A loop controls
   output logic            RAIL_A_RAMP_DOWN_FIXED_LIFT_EN,
   output logic      [2:0] RAIL_A_RAMP_DOWN_PULL_SCALE,
   output logic      [6:0] RAIL_A_RAMP_DOWN_PULL_CURRENT,
   output logic            RAIL_A_LOWPOWER_EXIT_LIFT,
   output logic            RAIL_A_LOWPOWER_EXIT_FILTER_CLEAR,
   output logic            RAIL_A_SENSE_GAIN_DOUBLE,
   output logic      [3:0] RAIL_A_SENSE_GAIN_EFFECTIVE,
   output logic            RAIL_A_RIPPLE_COMP_DOUBLE,
   output logic      [3:0] RAIL_A_RIPPLE_COMP_EFFECTIVE,
   // Rail B loop controls
   output logic            RAIL_B_RAMP_DOWN_FIXED_LIFT_EN,
   output logic      [2:0] RAIL_B_RAMP_DOWN_PULL_SCALE,
   output logic      [6:0] RAIL_B_RAMP_DOWN_PULL_CURRENT,
   output logic            RAIL_B_LOWPOWER_EXIT_LIFT,
   output logic            RAIL_B_LOWPOWER_EXIT_FILTER_CLEAR,
   output logic            RAIL_B_SENSE_GAIN_DOUBLE,
   output logic      [3:0] RAIL_B_SENSE_GAIN_EFFECTIVE,
   output logic            RAIL_B_RIPPLE_COMP_DOUBLE,
   output logic      [3:0] RAIL_B_RIPPLE_COMP_EFFECTIVE
);
   logic [7:0] rail_a_voltage_id_ramp_transition_comp_reg;
   logic [7:0] rail_b_voltage_id_ramp_transition_comp_reg;
   logic [7:0] rdata_next;
   logic       wr_a;
   logic       wr_b;

   dmt_rail_if rail_a_if ();
   dmt_rail_if rail_b_if ();

   // Address decode; any other address is ignored on write
   assign wr_a = REG_WR_EN && (REG_ADDR == dmt_pkg::RAIL_A_COMP_OFS);
   assign wr_b = REG_WR_EN && (REG_ADDR == dmt_pkg::RAIL_B_COMP_OFS);

   // Rail A storage; all eight bits are writable
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rail_a_voltage_id_ramp_transition_comp_reg <= dmt_pkg::RAIL_A_COMP_RST;
      end else if (wr_a) begin
         rail_a_voltage_id_ramp_transition_comp_reg <= REG_WDATA;
      end
   end

   // Rail B storage
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rail_b_voltage_id_ramp_transition_comp_reg <= dmt_pkg::RAIL_B_COMP_RST;
      end else if (wr_b) begin
         rail_b_voltage_id_ramp_transition_comp_reg <= REG_WDATA;
      end
   end

   // Read mux; a read in the same cycle as a write sees the old value
   always_comb begin
      rdata_next = dmt_pkg::UNMAPPED_RDATA;
      unique case (REG_ADDR)
         dmt_pkg::RAIL_A_COMP_OFS: rdata_next = rail_a_voltage_id_ramp_transition_comp_reg;
         dmt_pkg::RAIL_B_COMP_OFS: rdata_next = rail_b_voltage_id_ramp_transition_comp_reg;
         default:                  rdata_next = dmt_pkg::UNMAPPED_RDATA;
      endcase
   end

   // Read data held until the next read so a slow serial engine can shift it
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         REG_RDATA <= dmt_pkg::UNMAPPED_RDATA;
      end else if (REG_RD_EN) begin
         REG_RDATA <= rdata_next;
      end
   end

   // One-cycle answer strobe for each read
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         REG_RD_VALID <= 1'b0;
      end else begin
         REG_RD_VALID <= REG_RD_EN;
      end
   end

   // Settings into the rail decoders
   assign rail_a_if.cfg          = rail_a_voltage_id_ramp_transition_comp_reg;
   assign rail_a_if.lift_setting = RAIL_A_LIFT_CURRENT_SETTING;
   assign rail_a_if.gain_code    = RAIL_A_SENSE_GAIN_CODE;
   assign rail_a_if.ripple_code  = RAIL_A_RIPPLE_COMP_CODE;
   assign rail_b_if.cfg          = rail_b_voltage_id_ramp_transition_comp_reg;
   assign rail_b_if.lift_setting = RAIL_B_LIFT_CURRENT_SETTING;
   assign rail_b_if.gain_code    = RAIL_B_SENSE_GAIN_CODE;
   assign rail_b_if.ripple_code  = RAIL_B_RIPPLE_COMP_CODE;

   dmt_rail_ctrl u_rail_a (
      .clk   (CLK),
      .rst_n (RSTN),
      .rif   (rail_a_if.rail)
   );

   dmt_rail_ctrl u_rail_b (
      .clk   (CLK),
      .rst_n (RSTN),
      .rif   (rail_b_if.rail)
   );

   // Rail A controls out of the decoder flops
   assign RAIL_A_RAMP_DOWN_FIXED_LIFT_EN    = rail_a_if.fixed_lift_en;
   assign RAIL_A_RAMP_DOWN_PULL_SCALE       = rail_a_if.pull_scale;
   assign RAIL_A_RAMP_DOWN_PULL_CURRENT     = rail_a_if.pull_current;
   assign RAIL_A_LOWPOWER_EXIT_LIFT         = rail_a_if.exit_lift;
   assign RAIL_A_LOWPOWER_EXIT_FILTER_CLEAR = rail_a_if.filter_clear;
   assign RAIL_A_SENSE_GAIN_DOUBLE          = rail_a_if.gain_double;
   assign RAIL_A_SENSE_GAIN_EFFECTIVE       = rail_a_if.gain_eff;
   assign RAIL_A_RIPPLE_COMP_DOUBLE         = rail_a_if.ripple_double;
   assign RAIL_A_RIPPLE_COMP_EFFECTIVE      = rail_a_if.ripple_eff;

   // Rail B controls out of the decoder flops
   assign RAIL_B_RAMP_DOWN_FIXED_LIFT_EN    = rail_b_if.fixed_lift_en;
   assign RAIL_B_RAMP_DOWN_PULL_SCALE       = rail_b_if.pull_scale;
   assign RAIL_B_RAMP_DOWN_PULL_CURRENT     = rail_b_if.pull_current;
   assign RAIL_B_LOWPOWER_EXIT_LIFT         = rail_b_if.exit_lift;
   assign RAIL_B_LOWPOWER_EXIT_FILTER_CLEAR = rail_b_if.filter_clear;
   assign RAIL_B_SENSE_GAIN_DOUBLE          = rail_b_if.gain_double;
   assign RAIL_B_SENSE_GAIN_EFFECTIVE       = rail_b_if.gain_eff;
   assign RAIL_B_RIPPLE_COMP_DOUBLE         = rail_b_if.ripple_double;
   assign RAIL_B_RIPPLE_COMP_EFFECTIVE      = rail_b_if.ripple_eff;
endmodule

/* File: tb/dmt_comp_regs_checker.sv */
// Port assertions for the rail A and B compensation register bank
`timescale 1ns/1ps
module dmt_comp_regs_checker (
   input wire logic       CLK,
   input wire logic       RSTN,
   input wire logic       REG_WR_EN,
   input wire logic       REG_RD_EN,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA,
   input wire logic       REG_RD_VALID,
   input wire logic [2:0] RAIL_A_SENSE_GAIN_CODE,
   input wire logic [2:0] RAIL_A_RIPPLE_COMP_CODE,
   input wire logic [3:0] RAIL_B_LIFT_CURRENT_SETTING,
   input wire logic       RAIL_A_RAMP_DOWN_FIXED_LIFT_EN,
   input wire logic [2:0] RAIL_A_RAMP_DOWN_PULL_SCALE,
   input wire logic       RAIL_A_LOWPOWER_EXIT_LIFT,
   input wire logic       RAIL_A_LOWPOWER_EXIT_FILTER_CLEAR,
   input wire logic       RAIL_A_SENSE_GAIN_DOUBLE,
   input wire logic [3:0] RAIL_A_SENSE_GAIN_EFFECTIVE,
   input wire logic       RAIL_A_RIPPLE_COMP_DOUBLE,
   input wire logic [3:0] RAIL_A_RIPPLE_COMP_EFFECTIVE,
   input wire logic       RAIL_B_RAMP_DOWN_FIXED_LIFT_EN,
   input wire logic [2:0] RAIL_B_RAMP_DOWN_PULL_SCALE,
   input wire logic [6:0] RAIL_B_RAMP_DOWN_PULL_CURRENT,
   input wire logic       RAIL_B_LOWPOWER_EXIT_LIFT,
   input wire logic       RAIL_B_LOWPOWER_EXIT_FILTER_CLEAR,
   input wire logic       RAIL_B_SENSE_GAIN_DOUBLE,
   input wire logic       RAIL_B_RIPPLE_COMP_DOUBLE
);
   // One clock domain, so one default clock and reset
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);

   read_answer_a: assert property (REG_RD_EN |=> REG_RD_VALID)
      else $error("read strobe not answered");
   no_stray_valid_a: assert property (!REG_RD_EN |=> !REG_RD_VALID)
      else $error("valid without read");
   unmapped_zero_a: assert property (REG_RD_EN && REG_ADDR > 8'h01 |=> REG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   // Bit 7 is inverted on its way out, the rest pass straight
   rail_a_fields_a: assert property (REG_WR_EN && REG_ADDR == 8'h00 |-> ##2
      {RAIL_A_RAMP_DOWN_FIXED_LIFT_EN, RAIL_A_RAMP_DOWN_PULL_SCALE, RAIL_A_LOWPOWER_EXIT_LIFT,
       RAIL_A_LOWPOWER_EXIT_FILTER_CLEAR, RAIL_A_SENSE_GAIN_DOUBLE, RAIL_A_RIPPLE_COMP_DOUBLE}
      == ($past(REG_WDATA, 2) ^ 8'h80)) else $error("rail A controls differ from write");
   rail_b_fields_a: assert property (REG_WR_EN && REG_ADDR == 8'h01 |-> ##2
      {RAIL_B_RAMP_DOWN_FIXED_LIFT_EN, RAIL_B_RAMP_DOWN_PULL_SCALE, RAIL_B_LOWPOWER_EXIT_LIFT,
       RAIL_B_LOWPOWER_EXIT_FILTER_CLEAR, RAIL_B_SENSE_GAIN_DOUBLE, RAIL_B_RIPPLE_COMP_DOUBLE}
      == ($past(REG_WDATA, 2) ^ 8'h80)) else $error("rail B controls differ from write");
   gain_a_double_a: assert property ($past(RSTN) |-> RAIL_A_SENSE_GAIN_EFFECTIVE ==
      (RAIL_A_SENSE_GAIN_DOUBLE ? {$past(RAIL_A_SENSE_GAIN_CODE), 1'b0}
                                : {1'b0, $past(RAIL_A_SENSE_GAIN_CODE)}))
      else $error("rail A gain scaling wrong");
   ripple_a_double_a: assert property ($past(RSTN) |-> RAIL_A_RIPPLE_COMP_EFFECTIVE ==
      (RAIL_A_RIPPLE_COMP_DOUBLE ? {$past(RAIL_A_RIPPLE_COMP_CODE), 1'b0}
                                 : {1'b0, $past(RAIL_A_RIPPLE_COMP_CODE)}))
      else $error("rail A ripple scaling wrong");
   pull_b_scale_a: assert property ($past(RSTN) |-> RAIL_B_RAMP_DOWN_PULL_CURRENT ==
      {3'h0, $past(RAIL_B_LIFT_CURRENT_SETTING)} * {4'h0, RAIL_B_RAMP_DOWN_PULL_SCALE})
      else $error("rail B pull current wrong");

   cov_write_a: cover property (REG_WR_EN && REG_ADDR == 8'h00);
   cov_read_b: cover property (REG_RD_EN && REG_ADDR == 8'h01);
   cov_unmapped: cover property (REG_RD_EN && REG_ADDR > 8'h01);
endmodule

/* File: tb/dmt_host_model.sv */
// Host model driving the byte register port of the bank
`timescale 1ns/1ps
module dmt_host_model (
   input  wire logic       clk,
   output logic            wr_en,
   output logic            rd_en,
   output logic      [7:0] addr,
   output logic      [7:0] wdata,
   input  wire logic [7:0] rdata,
   input  wire logic       rd_valid
);
   initial begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
   end
   // One access per call; both strobes at once give a read beside a write
   task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic v);
      @(posedge clk);
      wr_en <= w;
      rd_en <= r;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      // Released lines show inverted stale values, never a helpful copy
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
      #1;
      q = rdata;
      v = rd_valid;
   endtask
endmodule

/* File: tb/dmt_comp_regs_bench.sv */
// Self-checking bench for the rail A and B compensation register bank
`timescale 1ns/1ps
module dmt_comp_regs_bench;
   logic        CLK = 1'b0;
   logic        RSTN = 1'b0;
   logic [3:0]  la = 4'h5;
   logic [3:0]  lb = 4'ha;
   logic [2:0]  ga = 3'h3;
   logic [2:0]  gb = 3'h6;
   logic [2:0]  ra = 3'h1;
   logic [2:0]  rb = 3'h7;
   wire logic   wr_en, rd_en, rd_valid;
   wire logic [7:0] addr, wdata, rdata;
   wire logic [22:0] oa, ob;
   logic [7:0]  d, q;
   logic        v;
   int          errors = 0;
   int          n_compared = 0;
   int          cyc = 0;

   always #25 CLK = ~CLK;

   dmt_host_model dmt_host_model_inst (.clk(CLK), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid));

   dmt_comp_regs dmt_comp_regs_inst (.CLK(CLK), .RSTN(RSTN), .REG_WR_EN(wr_en),
      .REG_RD_EN(rd_en), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
      .REG_RD_VALID(rd_valid), .RAIL_A_LIFT_CURRENT_SETTING(la), .RAIL_A_SENSE_GAIN_CODE(ga),
      .RAIL_A_RIPPLE_COMP_CODE(ra), .RAIL_B_LIFT_CURRENT_SETTING(lb),
      .RAIL_B_SENSE_GAIN_CODE(gb), .RAIL_B_RIPPLE_COMP_CODE(rb),
      .RAIL_A_RAMP_DOWN_FIXED_LIFT_EN(oa[22]), .RAIL_A_RAMP_DOWN_PULL_SCALE(oa[21:19]),
      .RAIL_A_RAMP_DOWN_PULL_CURRENT(oa[18:12]), .RAIL_A_LOWPOWER_EXIT_LIFT(oa[11]),
      .RAIL_A_LOWPOWER_EXIT_FILTER_CLEAR(oa[10]), .RAIL_A_SENSE_GAIN_DOUBLE(oa[9]),
      .RAIL_A_SENSE_GAIN_EFFECTIVE(oa[8:5]), .RAIL_A_RIPPLE_COMP_DOUBLE(oa[4]),
      .RAIL_A_RIPPLE_COMP_EFFECTIVE(oa[3:0]),
      .RAIL_B_RAMP_DOWN_FIXED_LIFT_EN(ob[22]), .RAIL_B_RAMP_DOWN_PULL_SCALE(ob[21:19]),
      .RAIL_B_RAMP_DOWN_PULL_CURRENT(ob[18:12]), .RAIL_B_LOWPOWER_EXIT_LIFT(ob[11]),
      .RAIL_B_LOWPOWER_EXIT_FILTER_CLEAR(ob[10]), .RAIL_B_SENSE_GAIN_DOUBLE(ob[9]),
      .RAIL_B_SENSE_GAIN_EFFECTIVE(ob[8:5]), .RAIL_B_RIPPLE_COMP_DOUBLE(ob[4]),
      .RAIL_B_RIPPLE_COMP_EFFECTIVE(ob[3:0]));

   // Expected loop controls of one rail, from its byte and side settings
   function automatic logic [22:0] dec(logic [7:0] b, logic [3:0] l, logic [2:0] g,
                                       logic [2:0] r);
      dec = {~b[7], b[6:4], {3'h0, l} * {4'h0, b[6:4]}, b[3:1],
             b[1] ? {g, 1'b0} : {1'b0, g}, b[0], b[0] ? {r, 1'b0} : {1'b0, r}};
   endfunction

   task automatic chk(input logic [22:0] got, input logic [22:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      dmt_host_model_inst.xfer(1'b0, 1'b1, a, 8'h00, q, v);
      chk(23'({v, q}), 23'({1'b1, exp}));
   endtask

   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Whole run needs about a hundred cycles; a hang is cut well after that
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         stop_test();
      end
   end

   initial begin
      for (int k = 0; k < 2; k++) begin
         repeat (6) @(posedge CLK);
         RSTN <= 1'b1;
         rd(8'h00, 8'h0c);
         rd(8'h01, 8'h94);
         chk(oa, dec(8'h0c, la, ga, ra));
         chk(ob, dec(8'h94, lb, gb, rb));
         if (k == 0) begin
            // Every pull code on both rails, with side settings moving too
            for (int i = 0; i < 8; i++) begin
               d = 8'(i * 8'h11) ^ {i[0], 7'h0a};
               @(posedge CLK);
               la <= 4'(15 - i);
               lb <= 4'(i + 8);
               ga <= 3'(i);
               gb <= 3'(7 - i);
               ra <= 3'(i + 3);
               rb <= 3'(i + 5);
               dmt_host_model_inst.xfer(1'b1, 1'b0, 8'h00, d, q, v);
               dmt_host_model_inst.xfer(1'b1, 1'b0, 8'h01, ~d, q, v);
               // Reads first: the decoded controls trail the write by one edge
               rd(8'h00, d);
               rd(8'h01, ~d);
               chk(oa, dec(d, la, ga, ra));
               chk(ob, dec(~d, lb, gb, rb));
            end
            // Unmapped places ignore writes and read as zero
            dmt_host_model_inst.xfer(1'b1, 1'b0, 8'h02, 8'hff, q, v);
            rd(8'h02, 8'h00);
            rd(8'hff, 8'h00);
            rd(8'h01, ~d);
            // Read beside a write to the same place returns the old byte
            dmt_host_model_inst.xfer(1'b1, 1'b1, 8'h00, 8'h3c, q, v);
            chk(23'({v, q}), 23'({1'b1, d}));
            rd(8'h00, 8'h3c);
            chk(oa, dec(8'h3c, la, ga, ra));
            @(posedge CLK);
            RSTN <= 1'b0;
         end
      end
      stop_test();
   end
endmodule

bind dmt_comp_regs dmt_comp_regs_checker dmt_comp_regs_checker_inst (.*);
